// >>> rtl/e1_init_host.sv
`timescale 1ns/1ps
`default_nettype none
module e1_init_host
    import e1pm_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // register port to framer
    e1pm_if.host BUS,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // framer request seen
    output logic IRQ_SEEN_O
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_REQ = 2'b01,
        S_GAP = 2'b10,
        S_DONE = 2'b11
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [3:0] cmd;
        logic [29:0] mask;
        logic [5:0] step;
        logic req;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic transmit_all_ones_in_n;
        logic [7:0] last_vector;
        logic [31:0] prdata;
        logic irq_seen;
    } state_t;

    state_t st;
    state_t next_st;
    logic apb_wr;
    logic apb_rd;
    logic op_wr;
    logic [5:0] op_addr;
    logic [7:0] op_data;

    assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    assign apb_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;

    // --------------------
    // initialization script
    // --------------------
    always_comb begin
        op_wr = 1'b1;
        op_data = 8'h00;
        op_addr = OFS_CTRL;
        if (st.step == 6'd0) begin
            op_data = {4'h0, st.cmd[3:2], st.cmd[1], 1'b1};
        end else if (st.step <= 6'd32) begin
            op_addr = OFS_TS_BASE + (st.step - 6'd1);
        end else if (st.step <= 6'd36) begin
            op_addr = OFS_MASK0 + (st.step - 6'd33);
            op_data = 8'({2'h0, st.mask} >> (8 * (st.step - 6'd33)));
        end else begin
            case (st.step)
                6'd37: op_addr = OFS_SLOT_ERR;
                6'd38: op_addr = OFS_ALARM_CRC;
                6'd39: op_addr = OFS_BAD_ALIGN;
                6'd40: op_addr = OFS_VIOL_LOW;
                6'd41: op_addr = OFS_VIOL_HIGH;
                6'd42: op_addr = OFS_EBIT_ERR;
                6'd43: op_addr = OFS_CRC_ERR;
                6'd44: begin
                    op_wr = 1'b0;
                    op_addr = OFS_VECTOR;
                end
                default: op_data = {4'h0, st.cmd[3:2], st.cmd[1], 1'b0};
            endcase
        end
    end

    always_comb begin
        next_st = st;
        next_st.irq_seen = ~BUS.irq_n;
        if (apb_wr && PADDR_I == APB_CMD) begin
            next_st.cmd = {PWDATA_I[3:1], 1'b0};
            if (PWDATA_I[0] && (st.phase == S_IDLE || st.phase == S_DONE)) begin
                next_st.phase = S_REQ;
                next_st.step = 6'd0;
                next_st.transmit_all_ones_in_n = 1'b0;
            end
        end
        if (apb_wr && PADDR_I == APB_MASK) begin
            next_st.mask = PWDATA_I[29:0];
        end
        if (apb_rd) begin
            case (PADDR_I)
                APB_CMD: next_st.prdata = {28'h0000000, st.cmd};
                APB_MASK: next_st.prdata = {2'h0, st.mask};
                APB_STATUS: next_st.prdata = {16'h0000, st.last_vector, 5'h00, ~st.transmit_all_ones_in_n,
                                              st.phase == S_DONE, st.phase == S_REQ || st.phase == S_GAP};
                default: next_st.prdata = 32'h00000000;
            endcase
        end
        case (st.phase)
            S_IDLE: next_st.req = 1'b0;
            S_REQ: begin
                next_st.req = 1'b1;
                next_st.wr = op_wr;
                next_st.addr = op_addr;
                next_st.wdata = op_data;
                if (st.req && BUS.ack) begin
                    next_st.req = 1'b0;
                    if (!st.wr) begin
                        next_st.last_vector = BUS.rdata;
                    end
                    next_st.phase = S_GAP;
                end
            end
            S_GAP: begin
                if (st.step == 6'(NUM_STEPS - 1)) begin
                    next_st.phase = S_DONE;
                    next_st.transmit_all_ones_in_n = 1'b1;
                end else begin
                    next_st.step = st.step + 6'd1;
                    next_st.phase = S_REQ;
                end
            end
            S_DONE: next_st.req = 1'b0;
            default: next_st.phase = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st <= '0;
            st.cmd <= CMD_RESET;
            st.mask <= MASK_RESET;
            st.phase <= S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign BUS.req = st.req;
    assign BUS.wr = st.wr;
    assign BUS.addr = st.addr;
    assign BUS.wdata = st.wdata;
    assign BUS.transmit_all_ones_in_n = st.transmit_all_ones_in_n;
    assign PRDATA_O = st.prdata;
    assign PREADY_O = PSEL_I & PENABLE_I;
    assign PSLVERR_O = 1'b0;
    assign IRQ_SEEN_O = st.irq_seen;
endmodule : e1_init_host
`default_nettype wire

// >>> rtl/e1_status_bank.sv
// What this block does
// - vector word clears after host read
// - vector holds code of latest interrupt
// - resets never touch the counters
// - counters take host-written start values
// - host writes violation low byte first
// - counts bit errors in selected timeslot
// - counts multiframes with alarm and zero E-bit
// - counts errored frame alignment words
// - sixteen-bit violation counter, high then low
// - E-bit error low byte readable
// - CRC error low byte readable
// - all-ones sent while transmit input low
// - interrupts suspended after reset
// - host zeroes every timeslot control word
// - E-bits forced by side select on loss
// - thirty individually maskable interrupt sources
// - backplane offset shifts output bit positions
// - line code defaults to HDB3 bipolar
// - request output only when suspend cleared
// - host zeroes used counters before enabling
// - one-second intervals, timer flag high 8 ms
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module e1_status_bank
    import e1pm_pkg::*;
#(
    parameter int INTERVAL_CYCLES = INTERVAL_CYC,
    parameter int TIMER_HIGH_CYCLES = TIMER_HIGH_CYC
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // register port
    e1pm_if.device BUS,
    // receive line events
    input wire logic [4:0] SLOT_I,
    input wire logic BIT_ERROR_I,
    input wire logic MULTIFRAME_I,
    input wire logic RAI_I,
    input wire logic [1:0] EBIT_RX_I,
    input wire logic FAS_ERROR_I,
    input wire logic VIOLATION_I,
    input wire logic EBIT_ERROR_I,
    input wire logic CRC_ERROR_I,
    input wire logic CRC_SYNC_LOST_I,
    input wire logic [NUM_SRC-1:0] IRQ_EVENT_I,
    // transmit side
    input wire logic [1:0] EBIT_NORMAL_I,
    output logic [1:0] EBIT_TX_O,
    output logic TX_ALL_ONES_O,
    output logic [7:0] TX_SLOT_CTRL_O,
    output logic [1:0] LINE_CODE_O,
    output logic [4:0] BP_OFFSET_O,
    output logic INTERVAL_TIMER_O
);
    // --------------------
    // state
    // --------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [4:0] slot_sel;
        logic [4:0] bp_offset;
        logic [31:0] mask;
        logic [7:0] vector;
        logic pending;
        logic [7:0] rdata;
        logic ack;
        logic [31:0] sec_cnt;
        logic [31:0] tmr_cnt;
        logic [7:0] ebit_out;
        logic [31:0][7:0] ts_ctrl;
    } state_t;

    state_t st;
    state_t next_st;

    logic access;
    logic wr_hit;
    logic rd_vector;
    logic [4:0] inc8;
    logic [4:0] load8;
    logic [4:0][7:0] cnt8;
    logic [4:0] ovf8;
    logic [15:0] viol_cnt;
    logic [15:0] viol_load_val;
    logic viol_load;
    logic viol_ovf;
    logic [NUM_SRC-1:0] src;
    logic [NUM_SRC-1:0] live;
    logic [7:0] code;
    logic [7:0] rd_mux;
    logic [5:0] cnt_ofs [5];

    assign access = BUS.req & ~st.ack;
    assign wr_hit = access & BUS.wr;
    assign rd_vector = access & ~BUS.wr & (BUS.addr == OFS_VECTOR);

    // --------------------
    // counters
    // --------------------
    assign cnt_ofs[0] = OFS_SLOT_ERR;
    assign cnt_ofs[1] = OFS_ALARM_CRC;
    assign cnt_ofs[2] = OFS_BAD_ALIGN;
    assign cnt_ofs[3] = OFS_EBIT_ERR;
    assign cnt_ofs[4] = OFS_CRC_ERR;
    assign inc8[0] = BIT_ERROR_I & (SLOT_I == st.slot_sel);
    assign inc8[1] = MULTIFRAME_I & RAI_I & (EBIT_RX_I != 2'h3);
    assign inc8[2] = FAS_ERROR_I;
    assign inc8[3] = EBIT_ERROR_I;
    assign inc8[4] = CRC_ERROR_I;

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_cnt
            assign load8[g] = wr_hit & (BUS.addr == cnt_ofs[g]);
            event_counter #(.W(8)) u_cnt (
                .clk_i(CLK_I),
                .load_i(load8[g]),
                .load_val_i(BUS.wdata),
                .inc_i(inc8[g]),
                .count_o(cnt8[g]),
                .ovf_o(ovf8[g])
            );
        end
    endgenerate

    // byte writes merge into the live 16-bit value
    assign viol_load = wr_hit & ((BUS.addr == OFS_VIOL_HIGH) | (BUS.addr == OFS_VIOL_LOW));
    assign viol_load_val = (BUS.addr == OFS_VIOL_HIGH) ? {BUS.wdata, viol_cnt[7:0]}
                                                       : {viol_cnt[15:8], BUS.wdata};

    event_counter #(.W(16)) u_viol (
        .clk_i(CLK_I),
        .load_i(viol_load),
        .load_val_i(viol_load_val),
        .inc_i(VIOLATION_I),
        .count_o(viol_cnt),
        .ovf_o(viol_ovf)
    );

    // --------------------
    // interrupt sources and vector code
    // --------------------
    always_comb begin
        src = IRQ_EVENT_I;
        src[SRC_VIOL_OVF] = IRQ_EVENT_I[SRC_VIOL_OVF] | viol_ovf;
        for (int i = 0; i < 5; i++) begin
            src[SRC_CNT_OVF0 + i] = IRQ_EVENT_I[SRC_CNT_OVF0 + i] | ovf8[i];
        end
        live = src & st.mask[NUM_SRC-1:0];
        code = 8'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (live[i]) begin
                code = 8'(i + 1);
            end
        end
    end

    // --------------------
    // read mux
    // --------------------
    always_comb begin
        rd_mux = 8'h00;
        if (BUS.addr >= OFS_TS_BASE) begin
            rd_mux = st.ts_ctrl[BUS.addr[4:0]];
        end else begin
            case (BUS.addr)
                OFS_CTRL: rd_mux = st.ctrl;
                OFS_SLOT_SEL: rd_mux = {3'h0, st.slot_sel};
                OFS_BP_OFFSET: rd_mux = {3'h0, st.bp_offset};
                6'h04: rd_mux = st.mask[7:0];
                6'h05: rd_mux = st.mask[15:8];
                6'h06: rd_mux = st.mask[23:16];
                6'h07: rd_mux = st.mask[31:24];
                OFS_VECTOR: rd_mux = st.vector;
                OFS_SLOT_ERR: rd_mux = cnt8[0];
                OFS_ALARM_CRC: rd_mux = cnt8[1];
                OFS_BAD_ALIGN: rd_mux = cnt8[2];
                OFS_VIOL_HIGH: rd_mux = viol_cnt[15:8];
                OFS_VIOL_LOW: rd_mux = viol_cnt[7:0];
                OFS_EBIT_ERR: rd_mux = cnt8[3];
                OFS_CRC_ERR: rd_mux = cnt8[4];
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // --------------------
    // next state
    // --------------------
    always_comb begin
        next_st = st;
        next_st.ack = access;
        if (access) begin
            next_st.rdata = rd_mux;
        end
        if (wr_hit) begin
            if (BUS.addr >= OFS_TS_BASE) begin
                next_st.ts_ctrl[BUS.addr[4:0]] = BUS.wdata;
            end else begin
                case (BUS.addr)
                    OFS_CTRL: next_st.ctrl = BUS.wdata;
                    OFS_SLOT_SEL: next_st.slot_sel = BUS.wdata[4:0];
                    OFS_BP_OFFSET: next_st.bp_offset = BUS.wdata[4:0];
                    6'h04: next_st.mask[7:0] = BUS.wdata;
                    6'h05: next_st.mask[15:8] = BUS.wdata;
                    6'h06: next_st.mask[23:16] = BUS.wdata;
                    6'h07: next_st.mask[31:24] = {2'h0, BUS.wdata[5:0]};
                    default: next_st.ctrl = st.ctrl;
                endcase
            end
        end
        // read clears; a new event in the same cycle wins
        if (rd_vector) begin
            next_st.vector = 8'h00;
            next_st.pending = 1'b0;
        end
        if (code != 8'h00) begin
            next_st.vector = code;
            next_st.pending = 1'b1;
        end
        // one-second accumulation interval with 8 ms flag
        if (st.sec_cnt >= 32'(INTERVAL_CYCLES - 1)) begin
            next_st.sec_cnt = 32'h00000000;
            next_st.tmr_cnt = 32'(TIMER_HIGH_CYCLES);
        end else begin
            next_st.sec_cnt = st.sec_cnt + 32'h00000001;
            if (st.tmr_cnt != 32'h00000000) begin
                next_st.tmr_cnt = st.tmr_cnt - 32'h00000001;
            end
        end
        // E-bit level on loss of CRC-4 sync: TE side 0, NT side 1
        if (CRC_SYNC_LOST_I) begin
            next_st.ebit_out = {6'h00, {2{~st.ctrl[CTRL_TE]}}};
        end else begin
            next_st.ebit_out = {6'h00, EBIT_NORMAL_I};
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.ts_ctrl <= {32{TS_CTRL_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // --------------------
    // outputs
    // --------------------
    assign BUS.ack = st.ack;
    assign BUS.rdata = st.rdata;
    assign BUS.irq_n = ~(st.pending & ~st.ctrl[CTRL_SUSPEND]);
    assign TX_ALL_ONES_O = ~BUS.transmit_all_ones_in_n;
    assign TX_SLOT_CTRL_O = st.ts_ctrl[SLOT_I];
    assign LINE_CODE_O = st.ctrl[CTRL_CODE_LSB +: 2];
    assign BP_OFFSET_O = st.bp_offset;
    assign EBIT_TX_O = st.ebit_out[1:0];
    assign INTERVAL_TIMER_O = (st.tmr_cnt != 32'h00000000);
endmodule : e1_status_bank
`default_nettype wire

// >>> rtl/e1pm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface e1pm_if;
    logic req;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic irq_n;
    logic transmit_all_ones_in_n;
    modport device (input req, wr, addr, wdata, transmit_all_ones_in_n, output rdata, ack, irq_n);
    modport host (output req, wr, addr, wdata, transmit_all_ones_in_n, input rdata, ack, irq_n);
endinterface : e1pm_if
`default_nettype wire

// >>> rtl/e1pm_pkg.sv
`default_nettype none
package e1pm_pkg;
    // --------------------
    // device register map, parallel register port
    // --------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_SLOT_SEL = 6'h01;
    localparam logic [5:0] OFS_BP_OFFSET = 6'h02;
    localparam logic [5:0] OFS_MASK0 = 6'h04;
    localparam logic [5:0] OFS_VECTOR = 6'h12;
    localparam logic [5:0] OFS_SLOT_ERR = 6'h18;
    localparam logic [5:0] OFS_ALARM_CRC = 6'h19;
    localparam logic [5:0] OFS_BAD_ALIGN = 6'h1A;
    localparam logic [5:0] OFS_VIOL_HIGH = 6'h1C;
    localparam logic [5:0] OFS_VIOL_LOW = 6'h1D;
    localparam logic [5:0] OFS_EBIT_ERR = 6'h1E;
    localparam logic [5:0] OFS_CRC_ERR = 6'h1F;
    localparam logic [5:0] OFS_TS_BASE = 6'h20;
    // control word fields
    localparam int CTRL_SUSPEND = 0;
    localparam int CTRL_TE = 1;
    localparam int CTRL_CODE_LSB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [1:0] CODE_HDB3_BNRZ = 2'h0;
    localparam logic [7:0] TS_CTRL_RESET = 8'h00;
    // interrupt sources
    localparam int NUM_SRC = 30;
    localparam int SRC_VIOL_OVF = 5;
    localparam int SRC_CNT_OVF0 = 6;
    // --------------------
    // timing at 100 MHz
    // --------------------
    localparam int CLK_MHZ = 100;
    localparam int INTERVAL_MS = 1000;
    localparam int TIMER_HIGH_MS = 8;
    localparam int INTERVAL_CYC = INTERVAL_MS * 1000 * CLK_MHZ;
    localparam int TIMER_HIGH_CYC = TIMER_HIGH_MS * 1000 * CLK_MHZ;
    // --------------------
    // controller APB map
    // --------------------
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_MASK = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam logic [29:0] MASK_RESET = 30'h000000FF;
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam int NUM_STEPS = 46;
endpackage : e1pm_pkg
`default_nettype wire

// >>> rtl/event_counter.sv
`timescale 1ns/1ps
`default_nettype none
module event_counter #(
    parameter int W = 8
) (
    // clock
    input wire logic clk_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic inc_i,
    // result
    output logic [W-1:0] count_o,
    output logic ovf_o
);
    logic [W-1:0] next_count;

    // no reset: contents survive every reset
    always_comb begin
        next_count = count_o;
        if (load_i) begin
            next_count = load_val_i;
        end else if (inc_i) begin
            next_count = count_o + 1'b1;
        end
    end

    assign ovf_o = inc_i & ~load_i & (&count_o);

    always_ff @(posedge clk_i) begin
        count_o <= next_count;
    end
endmodule : event_counter
`default_nettype wire

// >>> tb/e1_perf_counters_and_init_bench.sv
`timescale 1ns/1ps
`default_nettype none
module e1_perf_counters_and_init_bench;
    import e1pm_pkg::*;
    logic clk;
    logic resetn;
    logic [4:0] slot;
    logic bit_err, mframe, rai, fas_err, viol, ebit_err, crc_err, sync_lost;
    logic [1:0] ebit_rx, ebit_norm, ebit_tx, line_code;
    logic [NUM_SRC-1:0] irq_ev;
    logic psel, penable, pwrite, pready, pslverr, irq_seen, all_ones, timer;
    logic [7:0] paddr, ts_ctrl;
    logic [4:0] bp_offset;
    logic [31:0] pwdata, prdata, q;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    e1pm_if bus();
    e1_status_bank #(.INTERVAL_CYCLES(100), .TIMER_HIGH_CYCLES(8)) i_e1_status_bank (
        .CLK_I(clk), .RESETN_I(resetn), .BUS(bus), .SLOT_I(slot), .BIT_ERROR_I(bit_err),
        .MULTIFRAME_I(mframe), .RAI_I(rai), .EBIT_RX_I(ebit_rx), .FAS_ERROR_I(fas_err),
        .VIOLATION_I(viol), .EBIT_ERROR_I(ebit_err), .CRC_ERROR_I(crc_err), .CRC_SYNC_LOST_I(sync_lost),
        .IRQ_EVENT_I(irq_ev), .EBIT_NORMAL_I(ebit_norm), .EBIT_TX_O(ebit_tx), .TX_ALL_ONES_O(all_ones),
        .TX_SLOT_CTRL_O(ts_ctrl), .LINE_CODE_O(line_code), .BP_OFFSET_O(bp_offset), .INTERVAL_TIMER_O(timer));
    e1_init_host i_e1_init_host (
        .CLK_I(clk), .RESETN_I(resetn), .BUS(bus), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .IRQ_SEEN_O(irq_seen));
    e1pm_properties i_e1pm_properties (
        .CLK_I(clk), .RESETN_I(resetn), .req(bus.req), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata),
        .rdata(bus.rdata), .ack(bus.ack), .irq_n(bus.irq_n), .transmit_all_ones_in_n(bus.transmit_all_ones_in_n));
    // --------------------
    // shared tasks
    // --------------------
    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        r = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic run_init(input logic [3:0] c);
        int k;
        apb(1'h1, APB_CMD, {28'h0, c}, q);
        repeat (4) @(posedge clk);
        check(all_ones, 1'h1, "all-ones during init");
        check(irq_seen, 1'h0, "request during init");
        k = 0;
        q = 32'h0;
        while (q[1:0] !== 2'h2 && k < 400) begin
            apb(1'h0, APB_STATUS, 32'h0, q);
            k++;
        end
        check(q[1:0], 2'h2, "init not done");
        check(all_ones, 1'h0, "all-ones not released");
    endtask : run_init
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            case (k)
                0: bit_err <= 1'h1;
                1: mframe <= 1'h1;
                2: fas_err <= 1'h1;
                3: ebit_err <= 1'h1;
                4: crc_err <= 1'h1;
                default: viol <= 1'h1;
            endcase
        end
        @(posedge clk);
        {bit_err, mframe, fas_err, ebit_err, crc_err, viol} <= 6'h00;
    endtask : pulse
    task automatic fire(input logic [NUM_SRC-1:0] ev);
        @(posedge clk);
        irq_ev <= ev;
        @(posedge clk);
        irq_ev <= '0;
        repeat (4) @(posedge clk);
    endtask : fire
    // --------------------
    // scenarios
    // --------------------
    task automatic t_reset();
        @(posedge clk);
        check(line_code, CODE_HDB3_BNRZ, "line code default");
        check(all_ones, 1'h1, "all-ones after reset");
        check(bp_offset, 5'h00, "offset default");
        fire(30'h8);
        check(irq_seen, 1'h0, "request while suspended");
        apb(1'h1, APB_MASK, 32'h7E8, q);
        apb(1'h0, APB_MASK, 32'h0, q);
        check(q, 32'h7E8, "mask readback");
        check(pslverr, 1'h0, "slave error");
        run_init(4'h3);
        check(irq_seen, 1'h0, "stale request");
        check(ts_ctrl, 8'h00, "timeslot word");
    endtask : t_reset
    task automatic t_mask();
        fire(30'h1000);
        check(irq_seen, 1'h0, "masked source raised request");
        fire(30'h1008);
        check(irq_seen, 1'h1, "unmasked source lost");
        run_init(4'h3);
        check(q[15:8], 8'h04, "vector code");
        check(irq_seen, 1'h0, "vector not cleared by read");
    endtask : t_mask
    task automatic t_ebits();
        @(posedge clk);
        ebit_norm <= 2'h2;
        sync_lost <= 1'h1;
        repeat (3) @(posedge clk);
        check(ebit_tx, 2'h0, "terminal side ebits");
        sync_lost <= 1'h0;
        repeat (3) @(posedge clk);
        check(ebit_tx, 2'h2, "normal ebits");
        sync_lost <= 1'h1;
        run_init(4'h5);
        check(ebit_tx, 2'h3, "network side ebits");
        check(line_code, 2'h1, "line code select");
        sync_lost <= 1'h0;
    endtask : t_ebits
    task automatic t_timer();
        int hi;
        hi = 0;
        repeat (200) begin
            @(posedge clk);
            if (timer === 1'h1) hi++;
        end
        check(hi, 32'h10, "timer high cycles");
    endtask : t_timer
    task automatic t_wrap(input int k);
        int n;
        logic [7:0] vec;
        n = (k == 5) ? 65536 : 256;
        vec = (k == 5) ? 8'h06 : 8'h07 + 8'(k);
        run_init(4'h3);
        // events that must not count
        if (k < 2) begin
            slot <= 5'h05;
            ebit_rx <= 2'h3;
            pulse(k, 10);
            slot <= 5'h00;
            ebit_rx <= 2'h1;
        end
        pulse(k, n - 1);
        repeat (4) @(posedge clk);
        check(irq_seen, 1'h0, "early overflow");
        pulse(k, 1);
        repeat (4) @(posedge clk);
        check(irq_seen, 1'h1, "overflow missing");
        run_init(4'h3);
        check(q[15:8], vec, "overflow vector");
    endtask : t_wrap
    task automatic t_keep();
        pulse(5, 3);
        resetn <= 1'h0;
        @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        check(i_e1_status_bank.viol_cnt, 16'h3, "count lost in reset");
        check(all_ones, 1'h1, "all-ones after reset");
    endtask : t_keep
    // --------------------
    // clock, timeout and main sequence
    // --------------------
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        resetn = 1'h0;
        slot = 5'h00;
        {bit_err, mframe, fas_err, viol, ebit_err, crc_err, sync_lost} = 7'h00;
        rai = 1'h1;
        ebit_rx = 2'h1;
        ebit_norm = 2'h0;
        irq_ev = '0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        t_reset();
        t_mask();
        t_ebits();
        t_timer();
        for (int k = 0; k < 6; k++) begin
            t_wrap(k);
        end
        t_keep();
        print_verdict();
    end
endmodule : e1_perf_counters_and_init_bench
`default_nettype wire

// >>> tb/e1pm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module e1pm_properties
    import e1pm_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // register port
    input wire logic req,
    input wire logic wr,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic irq_n,
    input wire logic transmit_all_ones_in_n
);
    typedef struct packed {
        logic sus;
        logic low_first;
        logic vec_read;
        logic [7:0] cnt_zero;
        logic [31:0] ts_zero;
    } watch_t;
    watch_t st;
    watch_t next_st;
    logic tw;
    assign tw = req && !ack && wr;
    // --------------------
    // host progress seen on the port
    // --------------------
    always_comb begin
        next_st = st;
        if (tw && addr == OFS_VIOL_LOW) next_st.low_first = 1'h1;
        if (tw && addr == OFS_VIOL_HIGH) next_st.low_first = 1'h0;
        if (tw && addr[5:3] == 3'h3 && wdata == 8'h00) next_st.cnt_zero[addr[2:0]] = 1'h1;
        if (tw && addr[5] && wdata == 8'h00) next_st.ts_zero[addr[4:0]] = 1'h1;
        if (req && !ack && !wr && addr == OFS_VECTOR) next_st.vec_read = 1'h1;
        if (tw && addr == OFS_CTRL) begin
            next_st.sus = wdata[CTRL_SUSPEND];
            // a new init pass starts from scratch
            if (wdata[CTRL_SUSPEND]) begin
                next_st.vec_read = 1'h0;
                next_st.cnt_zero = 8'h00;
                next_st.ts_zero = 32'h0;
            end
        end
    end
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st <= '0;
            st.sus <= 1'h1;
        end else begin
            st <= next_st;
        end
    end
    // --------------------
    // properties
    // --------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence s_release;
        tw && addr == OFS_CTRL && !wdata[CTRL_SUSPEND];
    endsequence
    sequence s_high_write;
        tw && addr == OFS_VIOL_HIGH;
    endsequence
    AST_ACK_ANSWER: assert property (req && !ack |=> ack)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(ack) |-> $past(req))
        else $error("ack without request");
    AST_IRQ_SUSPENDED: assert property (st.sus && $past(st.sus) |-> irq_n)
        else $error("request output while suspended");
    AST_IRQ_CAUSE: assert property ($fell(irq_n) |-> !st.sus)
        else $error("request output before release");
    AST_TRANSMIT_ALL_ONES_IN_RELEASE: assert property ($rose(transmit_all_ones_in_n) |-> !st.sus)
        else $error("all-ones ended before configuration");
    AST_TRANSMIT_ALL_ONES_IN_LOW: assert property (s_release |-> !transmit_all_ones_in_n)
        else $error("all-ones not held through init");
    AST_VIOL_ORDER: assert property (s_high_write |-> st.low_first)
        else $error("violation high byte before low byte");
    AST_COUNTERS_CLEARED: assert property (s_release |-> (st.cnt_zero & 8'hF7) == 8'hF7)
        else $error("counter not zeroed before release");
    AST_TS_CLEARED: assert property (s_release |-> &st.ts_zero)
        else $error("timeslot word not zeroed");
    AST_VECTOR_READ: assert property (s_release |-> st.vec_read)
        else $error("vector not read before release");
endmodule : e1pm_properties
`default_nettype wire
